// >>> irq_ack_pkg.sv
// constants shared by the interrupt rank search and the acknowledge logic
// assumes the controllers, the vector scheme and the acknowledge offsets below
package irq_ack_pkg;

  // ***************************************************
  // sizes
  // ***************************************************
  localparam int CTRL_COUNT = 2;
  localparam int CTRL_IDX_W = 1;
  localparam int SRC_COUNT = 64;
  localparam int FIRST_PROG_SRC = 8;
  localparam int EXT_COUNT = 7;
  localparam int LEVEL_W = 3;
  localparam int PRIO_W = 3;
  localparam int RANK_W = 4;
  localparam int KEY_W = LEVEL_W + RANK_W;
  localparam int SRC_IDX_W = 6;
  localparam int VEC_W = 8;
  localparam int ADDR_W = 12;

  // ***************************************************
  // ranking inside one level
  // ***************************************************
  localparam logic [RANK_W-1:0] MID_RANK = 4'h4;
  localparam logic [PRIO_W-1:0] PRIO_SPLIT = 3'h4;
  localparam logic [RANK_W-1:0] RANK_STEP = 4'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_ANY = 3'h0;

  // ***************************************************
  // acknowledge offsets within peripheral space
  // ***************************************************
  localparam logic [ADDR_W-1:0] GLOBAL_ACK_BASE = 12'hfe0;
  localparam logic [ADDR_W-1:0] GLOBAL_ACK_FIRST = 12'hfe4;
  localparam logic [ADDR_W-1:0] GLOBAL_ACK_LAST = 12'hffc;
  localparam logic [ADDR_W-1:0] CTRL_SW_ACK = 12'h0e0;
  localparam logic [ADDR_W-1:0] CTRL_LVL_ACK_FIRST = 12'h0e4;
  localparam logic [ADDR_W-1:0] CTRL_LVL_ACK_LAST = 12'h0fc;
  localparam int WORD_SHIFT = 2;

  // ***************************************************
  // vectors
  // ***************************************************
  localparam logic [VEC_W-1:0] VEC_BASE = 8'h40;
  localparam logic [VEC_W-1:0] VEC_STRIDE = 8'h40;
  localparam logic [VEC_W-1:0] SPURIOUS_VEC = 8'h18;

  // level carried by an acknowledge offset, counted in words from its base
  function automatic logic [LEVEL_W-1:0] ack_level(input logic [ADDR_W-1:0] addr,
                                                   input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] diff;
    diff = addr - base;
    return diff[WORD_SHIFT +: LEVEL_W];
  endfunction

endpackage

// >>> irq_rank_search.sv
// combinational search for the best pending unmasked source of one controller
// assumes pending, mask and field inputs are on the system clock; lines 1-7 come in synchronised
`timescale 1ns/10ps
module irq_rank_search
  import irq_ack_pkg::*;
(
  // source state
  input wire logic [SRC_COUNT-1:0] i_pending,
  input wire logic [SRC_COUNT-1:0] i_masked,
  input wire logic [SRC_COUNT*LEVEL_W-1:0] i_level,
  input wire logic [SRC_COUNT*PRIO_W-1:0] i_rank,
  input wire logic [FIRST_PROG_SRC-1:0] i_ext_line,
  // search scope, LEVEL_ANY searches every level
  input wire logic [LEVEL_W-1:0] i_level_filter,
  // result, key zero means nothing found
  output logic [KEY_W-1:0] o_key,
  output logic [SRC_IDX_W-1:0] o_src
);

  // ***************************************************
  // search
  // ***************************************************

  // ascending scan with strict compare: on a tie the lowest source wins
  always_comb
  begin
    logic [LEVEL_W-1:0] lvl;
    logic [PRIO_W-1:0] prio;
    logic [RANK_W-1:0] rnk;
    logic live;
    logic [KEY_W-1:0] cand;
    lvl = '0;
    prio = '0;
    rnk = '0;
    live = 1'b0;
    cand = '0;
    o_key = '0;
    o_src = '0;
    for (int s = 1; s < SRC_COUNT; s++)
    begin
      if (s < FIRST_PROG_SRC)
      begin
        // external line n sits at the mid-point of level n
        live = i_ext_line[s] & ~i_masked[s]; // RULE1
        lvl = LEVEL_W'(s);
        rnk = MID_RANK; // RULE1
      end
      else
      begin
        live = i_pending[s] & ~i_masked[s];
        lvl = i_level[s*LEVEL_W +: LEVEL_W]; // RULE1
        prio = i_rank[s*PRIO_W +: PRIO_W];
        // upper priorities step over the mid-point slot
        rnk = (prio >= PRIO_SPLIT) ? ({1'b0, prio} + RANK_STEP) : {1'b0, prio}; // RULE1
      end
      // level zero never requests
      if (lvl == LEVEL_ANY)
        live = 1'b0;
      if ((i_level_filter != LEVEL_ANY) && (lvl != i_level_filter))
        live = 1'b0;
      // level in the high bits ranks above any in-level rank
      cand = live ? {lvl, rnk} : '0; // RULE8
      if (cand > o_key)
      begin
        o_key = cand;
        o_src = SRC_IDX_W'(s);
      end
    end
  end

endmodule

// >>> irq_priority_ack_logic.sv
// interrupt level/priority ranking and acknowledge read service for all controllers
// assumes one processor acknowledge read at a time on the system clock; pins are asynchronous
//
// Operation
// (RULE1) Sources 8 to 63 take level and in-level priority from their fields, and external line n ranks at the mid-point of level n.
// (RULE2) An acknowledge read is decoded from its address, which carries the acknowledged level.
// (RULE3) Seven global level acknowledge words sit at offsets 0xfe4 to 0xffc, one per level 1 to 7.
// (RULE4) Every controller has its own acknowledge words beside the shared global ones.
// (RULE5) A global level read returns the best unmasked pending vector of that level over all controllers.
// (RULE6) The global space has no software acknowledge word, only the level words decode there.
// (RULE7) A controller's software acknowledge read returns its own best unmasked pending vector at any level.
// (RULE8) A higher level always outranks a lower one, and inside a level the priority field ranks, with the mid-point in place.
`timescale 1ns/10ps
module irq_priority_ack_logic
  import irq_ack_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // external request pins, line n on bit n-1, asynchronous
  input wire logic [EXT_COUNT-1:0] i_external_request_line,
  // source state of all controllers, controller c at slice c
  input wire logic [CTRL_COUNT*SRC_COUNT-1:0] i_src_pending,
  input wire logic [CTRL_COUNT*SRC_COUNT-1:0] i_src_masked,
  input wire logic [CTRL_COUNT*SRC_COUNT*LEVEL_W-1:0] i_interrupt_level_field,
  input wire logic [CTRL_COUNT*SRC_COUNT*PRIO_W-1:0] i_within_level_rank,
  // acknowledge read request
  input wire logic i_ack_req,
  input wire logic [CTRL_IDX_W-1:0] i_ack_ctrl,
  input wire logic [ADDR_W-1:0] i_ack_addr,
  // acknowledge answer
  output logic o_ack_valid,
  output logic o_ack_err,
  output logic [VEC_W-1:0] o_ack_vector
);

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic ack_valid;
    logic ack_err;
    logic [VEC_W-1:0] vector;
    logic [EXT_COUNT-1:0] ext_s1;
    logic [EXT_COUNT-1:0] ext_s2;
    logic [EXT_COUNT-1:0] ext_s3;
    logic [EXT_COUNT-1:0] ext_line;
  } state_t;

  state_t state;
  state_t next_state;

  logic is_global;
  logic is_sw;
  logic is_ctrl_lvl;
  logic [LEVEL_W-1:0] level_filter;
  logic [KEY_W-1:0] key [CTRL_COUNT];
  logic [SRC_IDX_W-1:0] src [CTRL_COUNT];
  logic [KEY_W-1:0] best_key;
  logic [SRC_IDX_W-1:0] best_src;
  logic [CTRL_IDX_W-1:0] best_ctrl;

  // ***************************************************
  // address decode
  // ***************************************************

  // the level of the read is taken from its offset
  always_comb
  begin
    is_global = (i_ack_addr >= GLOBAL_ACK_FIRST) && (i_ack_addr <= GLOBAL_ACK_LAST)
                && (i_ack_addr[WORD_SHIFT-1:0] == 2'h0); // RULE3 RULE6
    is_sw = (i_ack_addr == CTRL_SW_ACK); // RULE4
    is_ctrl_lvl = (i_ack_addr >= CTRL_LVL_ACK_FIRST) && (i_ack_addr <= CTRL_LVL_ACK_LAST)
                  && (i_ack_addr[WORD_SHIFT-1:0] == 2'h0); // RULE4
    if (is_global)
      level_filter = ack_level(i_ack_addr, GLOBAL_ACK_BASE); // RULE2
    else if (is_ctrl_lvl)
      level_filter = ack_level(i_ack_addr, CTRL_SW_ACK); // RULE2
    else
      level_filter = LEVEL_ANY; // RULE7
  end

  // ***************************************************
  // per-controller search
  // ***************************************************
  generate
    for (genvar c = 0; c < CTRL_COUNT; c++)
    begin : g_ctrl
      // only controller 0 owns the external lines
      logic [FIRST_PROG_SRC-1:0] ext_in;
      assign ext_in = (c == 0) ? {state.ext_line, 1'b0} : '0;
      irq_rank_search u_search (
        .i_pending(i_src_pending[c*SRC_COUNT +: SRC_COUNT]),
        .i_masked(i_src_masked[c*SRC_COUNT +: SRC_COUNT]),
        .i_level(i_interrupt_level_field[c*SRC_COUNT*LEVEL_W +: SRC_COUNT*LEVEL_W]),
        .i_rank(i_within_level_rank[c*SRC_COUNT*PRIO_W +: SRC_COUNT*PRIO_W]),
        .i_ext_line(ext_in),
        .i_level_filter(level_filter),
        .o_key(key[c]),
        .o_src(src[c])
      );
    end
  endgenerate

  // ***************************************************
  // winner across controllers
  // ***************************************************

  // global reads compare all controllers, lowest controller wins a tie
  always_comb
  begin
    best_key = key[i_ack_ctrl];
    best_src = src[i_ack_ctrl];
    best_ctrl = i_ack_ctrl;
    if (is_global)
    begin
      best_key = '0;
      best_src = '0;
      best_ctrl = '0;
      for (int c = 0; c < CTRL_COUNT; c++)
      begin
        if (key[c] > best_key) // RULE5
        begin
          best_key = key[c];
          best_src = src[c];
          best_ctrl = CTRL_IDX_W'(c);
        end
      end
    end
  end

  // ***************************************************
  // next state
  // ***************************************************

  // pins pass three flops; a change counts once stages two and three agree
  always_comb
  begin
    next_state = state;
    next_state.ext_s1 = i_external_request_line;
    next_state.ext_s2 = state.ext_s1;
    next_state.ext_s3 = state.ext_s2;
    for (int n = 0; n < EXT_COUNT; n++)
    begin
      if (state.ext_s2[n] == state.ext_s3[n])
        next_state.ext_line[n] = state.ext_s3[n];
    end
    next_state.ack_valid = i_ack_req;
    next_state.ack_err = 1'b0;
    if (i_ack_req)
    begin
      if (!(is_global || is_sw || is_ctrl_lvl))
      begin
        // unmapped offset answers with an error, never hangs
        next_state.ack_err = 1'b1;
        next_state.vector = SPURIOUS_VEC;
      end
      else if (best_key == '0)
        next_state.vector = SPURIOUS_VEC;
      else
        next_state.vector = VEC_BASE + VEC_W'(best_ctrl) * VEC_STRIDE + VEC_W'(best_src); // RULE5 RULE7
    end
  end

  // single register stage for all state
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      state <= '0;
    else
      state <= next_state;
  end

  assign o_ack_valid = state.ack_valid;
  assign o_ack_err = state.ack_err;
  assign o_ack_vector = state.vector;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_global_read;
    i_ack_req && is_global;
  endsequence

  sequence s_answer_ok;
    o_ack_valid && !o_ack_err;
  endsequence

  property p_answer_timing;
    i_ack_req |=> o_ack_valid;
  endproperty
  a_answer_timing: assert property (p_answer_timing) else $error("acknowledge not answered next cycle"); // RULE2

  property p_no_spurious_valid;
    !i_ack_req |=> !o_ack_valid;
  endproperty
  a_no_spurious_valid: assert property (p_no_spurious_valid) else $error("answer without request");

  property p_global_decoded;
    s_global_read |=> s_answer_ok;
  endproperty
  a_global_decoded: assert property (p_global_decoded) else $error("global level word refused"); // RULE3

  property p_global_no_sw;
    i_ack_req && (i_ack_addr == GLOBAL_ACK_BASE) |=> o_ack_err;
  endproperty
  a_global_no_sw: assert property (p_global_no_sw) else $error("global software word decoded"); // RULE6

  property p_global_level_match;
    (s_global_read and (best_key != '0)) |-> (best_key[KEY_W-1 -: LEVEL_W] == level_filter);
  endproperty
  a_global_level_match: assert property (p_global_level_match) else $error("global winner at wrong level"); // RULE5

  property p_ctrl_words;
    i_ack_req && (is_sw || is_ctrl_lvl) |=> s_answer_ok;
  endproperty
  a_ctrl_words: assert property (p_ctrl_words) else $error("controller word refused"); // RULE4

  property p_sw_vector;
    i_ack_req && is_sw && (best_key != '0) |=>
      o_ack_vector == VEC_BASE + VEC_W'($past(i_ack_ctrl)) * VEC_STRIDE + VEC_W'($past(best_src));
  endproperty
  a_sw_vector: assert property (p_sw_vector) else $error("software read vector wrong"); // RULE7

  property p_empty_spurious;
    i_ack_req && (best_key == '0) |=> o_ack_vector == SPURIOUS_VEC;
  endproperty
  a_empty_spurious: assert property (p_empty_spurious) else $error("empty search not spurious"); // RULE8

  property p_pin_sync;
    ##1 ($stable(i_external_request_line)) [*4] |-> state.ext_line == i_external_request_line;
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("external line not followed"); // RULE1

endmodule

// >>> ack_master.sv
// processor-side model that issues acknowledge reads
// assumes the block answers one cycle after the edge that takes a read
`timescale 1ns/10ps
module ack_master
  import irq_ack_pkg::*;
(
  // clock
  input wire logic i_clk,
  // answer from the block
  input wire logic i_ack_valid,
  input wire logic i_ack_err,
  input wire logic [VEC_W-1:0] i_ack_vector,
  // read request
  output logic o_ack_req,
  output logic [CTRL_IDX_W-1:0] o_ack_ctrl,
  output logic [ADDR_W-1:0] o_ack_addr
);
  // idle until the first read
  initial
  begin
    o_ack_req = 1'b0;
    o_ack_ctrl = '0;
    o_ack_addr = '0;
  end

  // held to the taking edge, answer read in the cycle after it
  task automatic read(input logic [CTRL_IDX_W-1:0] c, input logic [ADDR_W-1:0] a,
                      output logic [VEC_W+1:0] ans);
    @(negedge i_clk);
    o_ack_ctrl = c;
    o_ack_addr = a;
    o_ack_req = 1'b1;
    @(posedge i_clk);
    @(negedge i_clk);
    o_ack_req = 1'b0;
    o_ack_addr = ~a; // released address is not left looking valid
    ans = {i_ack_valid, i_ack_err, i_ack_vector};
  endtask
endmodule

// >>> irq_priority_ack_logic_tb.sv
// self-checking bench for the acknowledge ranking block
// assumes the ack_master model and the registered one-cycle answer
`timescale 1ns/10ps
module irq_priority_ack_logic_tb;
  import irq_ack_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [EXT_COUNT-1:0] ext = '0;
  logic [CTRL_COUNT*SRC_COUNT-1:0] pend = '0;
  logic [CTRL_COUNT*SRC_COUNT-1:0] mask = '0;
  logic [CTRL_COUNT*SRC_COUNT*LEVEL_W-1:0] lvl = '0;
  logic [CTRL_COUNT*SRC_COUNT*PRIO_W-1:0] prio = '0;
  logic req;
  logic [CTRL_IDX_W-1:0] ctrl;
  logic [ADDR_W-1:0] addr;
  logic valid;
  logic err;
  logic [VEC_W-1:0] vec;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  // *****************
  // clock and parts
  // *****************
  always #50 i_clk = ~i_clk;

  irq_priority_ack_logic DUT (.i_clk(i_clk), .i_reset(i_reset), .i_external_request_line(ext),
    .i_src_pending(pend), .i_src_masked(mask), .i_interrupt_level_field(lvl),
    .i_within_level_rank(prio), .i_ack_req(req), .i_ack_ctrl(ctrl), .i_ack_addr(addr),
    .o_ack_valid(valid), .o_ack_err(err), .o_ack_vector(vec));

  ack_master PART (.i_clk(i_clk), .i_ack_valid(valid), .i_ack_err(err), .i_ack_vector(vec),
    .o_ack_req(req), .o_ack_ctrl(ctrl), .o_ack_addr(addr));

  // *****************
  // helpers
  // *****************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a hung run must not pass silently
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic clr();
    @(negedge i_clk);
    pend = '0;
    mask = '0;
    lvl = '0;
    prio = '0;
    ext = '0;
  endtask

  task automatic src(input int c, input int s, input int l, input int p);
    pend[c*64+s] = 1'b1;
    lvl[(c*64+s)*3 +: 3] = l[2:0];
    prio[(c*64+s)*3 +: 3] = p[2:0];
  endtask

  // read and compare valid, error and vector together
  task automatic cmp(input logic [CTRL_IDX_W-1:0] c, input logic [ADDR_W-1:0] a,
                     input logic e, input logic [VEC_W-1:0] v);
    logic [VEC_W+1:0] got;
    PART.read(c, a, got);
    cmp_count++;
    if (got !== {1'b1, e, v})
    begin
      bad_count++;
      $display("unexpected answer at %0t: addr %h got %h want %h", $time, a, got, {1'b1, e, v});
    end
  endtask

  // *****************
  // scenarios
  // *****************
  task automatic t_levels();
    clr();
    for (int n = 1; n < 8; n++)
      src(0, 8 + n, n, 0);
    for (int n = 1; n < 8; n++)
    begin
      cmp(0, GLOBAL_ACK_BASE + 12'(4 * n), 1'b0, 8'(8'h48 + n));
      cmp(0, CTRL_SW_ACK + 12'(4 * n), 1'b0, 8'(8'h48 + n));
    end
  endtask

  task automatic t_prio();
    clr();
    src(0, 10, 3, 5);
    src(0, 20, 3, 6);
    src(1, 30, 3, 7);
    mask[94] = 1'b1; // masked best must be skipped
    cmp(1, 12'hfec, 1'b0, 8'h54);
  endtask

  task automatic t_mid();
    clr();
    ext[2] = 1'b1;
    src(0, 40, 3, 3);
    repeat (6) @(negedge i_clk); // synchroniser latency
    cmp(0, 12'hfec, 1'b0, 8'h43);
    src(0, 41, 3, 4);
    cmp(0, 12'hfec, 1'b0, 8'h69);
    mask[3] = 1'b1; // masked external line must drop out
    mask[41] = 1'b1;
    cmp(0, 12'hfec, 1'b0, 8'h68);
  endtask

  task automatic t_cross();
    clr();
    src(0, 12, 5, 2);
    src(1, 9, 5, 7);
    cmp(0, 12'hff4, 1'b0, 8'h89);
    cmp(0, 12'h0f4, 1'b0, 8'h4c);
    cmp(1, 12'h0f4, 1'b0, 8'h89);
  endtask

  task automatic t_sw();
    clr();
    src(0, 50, 2, 7);
    src(0, 51, 6, 0);
    src(1, 60, 7, 7);
    cmp(0, CTRL_SW_ACK, 1'b0, 8'h73);
    cmp(1, CTRL_SW_ACK, 1'b0, 8'hbc);
    cmp(0, 12'hff0, 1'b0, SPURIOUS_VEC);
  endtask

  task automatic t_bad();
    clr();
    src(0, 15, 4, 1);
    cmp(0, GLOBAL_ACK_BASE, 1'b1, SPURIOUS_VEC);
    cmp(0, 12'hfe6, 1'b1, SPURIOUS_VEC);
    cmp(0, 12'h100, 1'b1, SPURIOUS_VEC);
    src(1, 20, 0, 7); // level zero never requests
    cmp(1, CTRL_SW_ACK, 1'b0, SPURIOUS_VEC);
  endtask

  // main sequence, reset held for 20 cycles
  initial
  begin
    repeat (20) @(negedge i_clk);
    i_reset = 1'b0;
    t_levels();
    t_prio();
    t_mid();
    t_cross();
    t_sw();
    t_bad();
    end_of_test();
  end
endmodule
